// ---- rtl/dma_cmd_regs.sv ----
/*
  Command decoder and programmable register set of a two-port DMA controller.
  Assumes the host writes and reads one byte per strobe, each strobe a single
  clock pulse from logic on this clock; transfer engine lives elsewhere.
*/
`timescale 1ns/1ns
`include "dma_cmd_cfg.svh"
module dma_cmd_regs (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  input  wire logic [7:0]           wr_data,
  output logic      [7:0]           rd_data,
  input  wire logic                 op_done,
  input  wire logic [7:0]           op_data,
  input  wire logic                 end_of_block,
  input  wire logic                 ready_pin,
  input  wire logic                 interrupt_return_instruction,
  input  wire logic                 int_ack,
  input  wire logic                 int_enable_in,
  output logic      [7:0]           vector_out,
  output logic                      vector_drive_n,
  output logic                      bus_request,
  output logic                      int_pulse_n,
  output logic                      src_first_port,
  output logic                      write_port_used,
  output dma_cmd_pkg::xfer_mode_e   xfer_mode,
  output logic      [1:0]           first_timing,
  output logic      [1:0]           second_timing,
  output logic      [15:0]          first_addr,
  output logic      [15:0]          second_addr,
  output logic      [15:0]          byte_count,
  output logic                      ready_eff,
  output logic                      enabled
);
  import dma_cmd_pkg::*;

  typedef enum logic [3:0] {
    P_NONE, P_FIRST_LO, P_FIRST_HI, P_LEN_LO, P_LEN_HI, P_TIMING, P_SECOND_LO,
    P_SECOND_HI, P_INTCTL, P_PULSE, P_VECTOR, P_RDMASK, P_CMPMASK, P_CMPVAL
  } param_e;

  // Expected parameter bytes, bit i set means param_e(i) still to come.
  logic [13:0] pending_reg;
  logic        enabled_reg;
  logic        int_enable_reg;
  logic        wait_return_reg;
  logic        force_ready_reg;
  logic [1:0]  class_reg;
  logic        src_reg;
  logic [7:0]  first_port_reg, second_port_reg;
  logic [7:0]  mode_reg, ready_cfg_reg;
  logic [15:0] len_reg, start_first_reg, start_second_reg;
  logic [15:0] count_reg, addr_first_reg, addr_second_reg;
  logic [7:0]  first_timing_reg, second_timing_reg;
  logic [7:0]  interrupt_control, readback_mask, compare_mask, compare_value;
  logic [7:0]  pulse_compare_count, interrupt_vector_value;
  logic        match_reg, end_reg, int_pending_reg;
  logic [2:0]  ptr_reg;
  logic        status_next_reg;
  logic [2:0]  ready_sync;
  logic        ready_level;
  logic        timing_sel;
  logic [2:0]  ptr_first, ptr_after;
  logic [7:0]  rd_sel;
  logic        is_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic param_e first_pending(input logic [13:0] p);
    first_pending = P_NONE;
    for (int i = 13; i >= 1; i--) begin
      if (p[i]) first_pending = param_e'(i);
    end
  endfunction

  function automatic logic [7:0] read_mux(input logic [2:0] idx, input logic [7:0] st,
                                          input logic [15:0] c, input logic [15:0] a,
                                          input logic [15:0] b);
    unique case (idx)
      3'h0: read_mux = st;
      3'h1: read_mux = c[7:0];
      3'h2: read_mux = c[15:8];
      3'h3: read_mux = a[7:0];
      3'h4: read_mux = a[15:8];
      3'h5: read_mux = b[7:0];
      3'h6: read_mux = b[15:8];
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign is_cmd = wr_stb && (pending_reg == 14'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Ready pin synchroniser; a change counts once the last two stages agree.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_sync  <= 3'h0;
      ready_level <= 1'b0;
    end else begin
      ready_sync <= {ready_sync[1:0], ready_pin};
      if (ready_sync[2] == ready_sync[1]) ready_level <= ready_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command and parameter decode.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg      <= 14'h0000;
      class_reg        <= 2'h1;
      src_reg          <= 1'b1;
      first_port_reg   <= 8'h00;
      second_port_reg  <= 8'h00;
      mode_reg         <= 8'h00;
      ready_cfg_reg    <= 8'h00;
      len_reg          <= 16'h0000;
      start_first_reg  <= 16'h0000;
      start_second_reg <= 16'h0000;
      first_timing_reg <= `TIMING_RESET;
      second_timing_reg <= `TIMING_RESET;
      interrupt_control <= 8'h00;
      readback_mask    <= `MASK_RESET;
      compare_mask     <= 8'hFF;
      compare_value    <= 8'h00;
      pulse_compare_count <= 8'h00;
      interrupt_vector_value <= 8'h00;
      timing_sel       <= 1'b0;
    end else if (wr_stb) begin
      if (pending_reg != 14'h0000) begin
        pending_reg[first_pending(pending_reg)] <= 1'b0;
        unique case (first_pending(pending_reg))
          P_FIRST_LO:  start_first_reg[7:0]   <= wr_data;
          P_FIRST_HI:  start_first_reg[15:8]  <= wr_data;
          P_LEN_LO:    len_reg[7:0]           <= wr_data;
          P_LEN_HI:    len_reg[15:8]          <= wr_data;
          P_TIMING: begin
            if (timing_sel) first_timing_reg <= wr_data;
            else second_timing_reg <= wr_data;
          end
          P_SECOND_LO: start_second_reg[7:0]  <= wr_data;
          P_SECOND_HI: start_second_reg[15:8] <= wr_data;
          P_INTCTL: begin
            interrupt_control <= wr_data;
            pending_reg[P_PULSE]  <= wr_data[3];
            pending_reg[P_VECTOR] <= wr_data[4];
          end
          P_PULSE:     pulse_compare_count    <= wr_data;
          P_VECTOR:    interrupt_vector_value <= wr_data;
          P_RDMASK:    readback_mask          <= wr_data;
          P_CMPMASK:   compare_mask           <= wr_data;
          P_CMPVAL:    compare_value          <= wr_data;
          default: ;
        endcase
      end else if (!wr_data[7] && wr_data[1:0] != 2'h0) begin
        class_reg <= wr_data[1:0];
        src_reg   <= wr_data[2];
        pending_reg[P_FIRST_LO] <= wr_data[3];
        pending_reg[P_FIRST_HI] <= wr_data[4];
        pending_reg[P_LEN_LO]   <= wr_data[5];
        pending_reg[P_LEN_HI]   <= wr_data[6];
      end else if (!wr_data[7]) begin
        if (wr_data[2]) first_port_reg <= wr_data;
        else second_port_reg <= wr_data;
        timing_sel <= wr_data[2];
        pending_reg[P_TIMING] <= wr_data[6];
      end else if (wr_data[1:0] == 2'h1) begin
        mode_reg <= wr_data;
        pending_reg[P_SECOND_LO] <= wr_data[2];
        pending_reg[P_SECOND_HI] <= wr_data[3];
        pending_reg[P_INTCTL]    <= wr_data[4];
      end else if (wr_data[1:0] == 2'h2 && wr_data[2] == 1'b0) begin
        ready_cfg_reg <= wr_data;
      end else if (wr_data[1:0] == 2'h0) begin
        pending_reg[P_CMPMASK] <= wr_data[3];
        pending_reg[P_CMPVAL]  <= wr_data[4];
      end else if (wr_data[1:0] == 2'h3) begin
        unique case (wr_data)
          `CMD_GENERAL_RESET: begin
            first_timing_reg  <= `TIMING_RESET;
            second_timing_reg <= `TIMING_RESET;
            interrupt_control <= 8'h00;
          end
          `CMD_RESET_FIRST_TIMING:  first_timing_reg  <= `TIMING_RESET;
          `CMD_RESET_SECOND_TIMING: second_timing_reg <= `TIMING_RESET;
          `CMD_MASK_FOLLOWS:        pending_reg[P_RDMASK] <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable, interrupt and ready-forcing state.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enabled_reg     <= 1'b0;
      int_enable_reg  <= 1'b0;
      wait_return_reg <= 1'b0;
      force_ready_reg <= 1'b0;
    end else begin
      if (interrupt_return_instruction) wait_return_reg <= 1'b0;
      if (is_cmd) begin
        enabled_reg <= (wr_data == `CMD_DMA_ENABLE);
        unique case (wr_data)
          `CMD_INT_ENABLE:       int_enable_reg  <= 1'b1;
          `CMD_INT_DISABLE:      int_enable_reg  <= 1'b0;
          `CMD_INT_RESET:        int_enable_reg  <= 1'b0;
          `CMD_GENERAL_RESET: begin
            int_enable_reg  <= 1'b0;
            force_ready_reg <= 1'b0;
          end
          `CMD_FORCE_READY:      force_ready_reg <= 1'b1;
          `CMD_ENABLE_AFTER_RET: wait_return_reg <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters and status; hardware sets win over the clear command.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg       <= 16'h0000;
      addr_first_reg  <= 16'h0000;
      addr_second_reg <= 16'h0000;
      match_reg       <= 1'b0;
      end_reg         <= 1'b0;
      int_pending_reg <= 1'b0;
    end else begin
      if (is_cmd && wr_data == `CMD_STATUS_CLEAR) begin
        match_reg <= 1'b0;
        end_reg   <= 1'b0;
      end
      if (is_cmd && (wr_data == `CMD_INT_RESET || wr_data == `CMD_GENERAL_RESET)) int_pending_reg <= 1'b0;
      if (is_cmd && wr_data == `CMD_LOAD) begin
        count_reg       <= 16'h0000;
        addr_first_reg  <= start_first_reg;
        addr_second_reg <= start_second_reg;
      end else if (is_cmd && wr_data == `CMD_CONTINUE) begin
        count_reg <= 16'h0000;
      end else if (op_done && enabled_reg) begin
        count_reg <= 16'(count_reg + 16'h0001);
        if (!first_port_reg[5] && !(class_reg == 2'h2 && !src_reg)) begin
          addr_first_reg <= first_port_reg[4] ? 16'(addr_first_reg + 16'h0001)
                                              : 16'(addr_first_reg - 16'h0001);
        end
        if (!(class_reg == 2'h2 && src_reg) && !second_port_reg[5]) begin
          addr_second_reg <= second_port_reg[4] ? 16'(addr_second_reg + 16'h0001)
                                                : 16'(addr_second_reg - 16'h0001);
        end
        if (((op_data ^ compare_value) & ~compare_mask) == 8'h00) begin
          match_reg <= 1'b1;
          if (interrupt_control[1] && int_enable_reg) int_pending_reg <= 1'b1;
        end
      end
      if (end_of_block) begin
        end_reg <= 1'b1;
        if (interrupt_control[0] && int_enable_reg) int_pending_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback pointer.

  readback_select u_first (
    .current         (`RD_IDX_LAST),
    .mask            (readback_mask[6:0]),
    .include_current (1'b0),
    .next_index      (ptr_first)
  );

  readback_select u_after (
    .current         (ptr_reg),
    .mask            (readback_mask[6:0]),
    .include_current (1'b0),
    .next_index      (ptr_after)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg         <= `RD_IDX_STATUS;
      status_next_reg <= 1'b0;
    end else if (is_cmd && wr_data == `CMD_POINTER_RESET) begin
      ptr_reg         <= ptr_first;
      status_next_reg <= 1'b0;
    end else if (is_cmd && wr_data == `CMD_STATUS_READ) begin
      status_next_reg <= 1'b1;
    end else if (rd_stb) begin
      if (status_next_reg) status_next_reg <= 1'b0;
      else ptr_reg <= ptr_after;
    end
  end

  always_comb begin
    rd_sel = read_mux(status_next_reg ? `RD_IDX_STATUS : ptr_reg,
                      {2'b00, end_reg, match_reg, int_pending_reg, 1'b0, ready_eff, 1'b1},
                      count_reg, addr_first_reg, addr_second_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data         <= 8'h00;
      vector_out      <= 8'h00;
      vector_drive_n  <= 1'b1;
      bus_request     <= 1'b0;
      int_pulse_n     <= 1'b1;
      src_first_port  <= 1'b1;
      write_port_used <= 1'b1;
      xfer_mode       <= MODE_BYTE;
      first_timing    <= 2'h0;
      second_timing   <= 2'h0;
      first_addr      <= 16'h0000;
      second_addr     <= 16'h0000;
      byte_count      <= 16'h0000;
      ready_eff       <= 1'b0;
      enabled         <= 1'b0;
    end else begin
      if (rd_stb) rd_data <= rd_sel;
      vector_out <= interrupt_control[5] ?
                    {interrupt_vector_value[7:3],
                     (match_reg && end_reg) ? `VEC_CAUSE_BOTH :
                     end_reg ? `VEC_CAUSE_END :
                     match_reg ? `VEC_CAUSE_MATCH : `VEC_CAUSE_READY,
                     interrupt_vector_value[0]} : interrupt_vector_value;
      vector_drive_n  <= !(int_ack && int_enable_in && int_pending_reg);
      bus_request     <= enabled_reg && !wait_return_reg && ready_eff;
      int_pulse_n     <= !(op_done && enabled_reg && interrupt_control[2] &&
                           pulse_compare_count == count_reg[7:0]);
      src_first_port  <= src_reg;
      write_port_used <= class_reg != 2'h2;
      xfer_mode       <= xfer_mode_e'(mode_reg[6:5]);
      first_timing    <= first_timing_reg[1:0];
      second_timing   <= second_timing_reg[1:0];
      first_addr      <= addr_first_reg;
      second_addr     <= addr_second_reg;
      byte_count      <= count_reg;
      ready_eff       <= force_ready_reg || (ready_level == ready_cfg_reg[3]);
      enabled         <= enabled_reg;
    end
  end
endmodule

// ---- rtl/dma_cmd_cfg.svh ----
/*
  Constants for the command and register block of the two-port DMA controller.
  Assumes inclusion by the design modules only.
*/
`ifndef DMA_CMD_CFG_SVH
`define DMA_CMD_CFG_SVH
`define CMD_GENERAL_RESET      8'hC3
`define CMD_RESET_FIRST_TIMING 8'hC7
`define CMD_RESET_SECOND_TIMING 8'hCB
`define CMD_LOAD               8'hCF
`define CMD_CONTINUE           8'hD3
`define CMD_INT_ENABLE         8'hAB
`define CMD_INT_DISABLE        8'hAF
`define CMD_INT_RESET          8'hA3
`define CMD_DMA_ENABLE         8'h87
`define CMD_DMA_DISABLE        8'h83
`define CMD_MASK_FOLLOWS       8'hBB
`define CMD_POINTER_RESET      8'hA7
`define CMD_STATUS_READ        8'hBF
`define CMD_FORCE_READY        8'hB3
`define CMD_ENABLE_AFTER_RET   8'hB7
`define CMD_STATUS_CLEAR       8'h8B
`define TIMING_RESET           8'hCF
`define MASK_RESET             8'h7F
`define RD_IDX_STATUS          3'h0
`define RD_IDX_LAST            3'h6
`define VEC_CAUSE_READY        2'h0
`define VEC_CAUSE_MATCH        2'h1
`define VEC_CAUSE_END          2'h2
`define VEC_CAUSE_BOTH         2'h3
`endif

// ---- rtl/dma_cmd_pkg.sv ----
/*
  Types shared by the DMA command block.
  Assumes the constants header sits beside it.
*/
package dma_cmd_pkg;
  typedef enum logic [1:0] {
    MODE_BYTE, MODE_CONTINUOUS, MODE_BURST, MODE_OTHER
  } xfer_mode_e;
  typedef logic [7:0] byte_t;
endpackage

// ---- rtl/readback_select.sv ----
/*
  Next-register search for the readback pointer.
  Assumes a seven-bit mask with bit 0 the status register.
*/
`timescale 1ns/1ns
`include "dma_cmd_cfg.svh"
module readback_select (
  input  wire logic [2:0] current,
  input  wire logic [6:0] mask,
  input  wire logic       include_current,
  output logic      [2:0] next_index
);
  import dma_cmd_pkg::*;

  // Walks forward cyclically to the first enabled register.
  always_comb begin
    logic [2:0] idx;
    logic       found;
    idx = current;
    found = 1'b0;
    next_index = current;
    for (int k = 0; k < 7; k++) begin
      if (!found && (k != 0 || !include_current)) begin
        idx = (idx == `RD_IDX_LAST) ? 3'h0 : 3'(idx + 3'h1);
      end
      if (!found && mask[idx]) begin
        next_index = idx;
        found = 1'b1;
      end
    end
  end
endmodule

// ---- sim/dma_cmd_asserts.sv ----
/*
  Concurrent checks on the ports of the DMA command block.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ns
module dma_cmd_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wr_stb,
  input wire logic [7:0]  wr_data,
  input wire logic        bus_request,
  input wire logic [1:0]  first_timing,
  input wire logic [15:0] first_addr,
  input wire logic [15:0] second_addr,
  input wire logic [15:0] byte_count,
  input wire logic        ready_eff,
  input wire logic        enabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_enable;
    (wr_stb && wr_data == 8'h87) ##1 !wr_stb |-> ##1 enabled;
  endproperty
  a_enable: assert property (p_enable) else $error("enable command ignored");
  property p_cmd_disables;
    (wr_stb && wr_data[7] && wr_data[1:0] == 2'h3 && wr_data != 8'h87) |-> ##2 !enabled;
  endproperty
  a_cmd_disables: assert property (p_cmd_disables) else $error("command left device enabled");
  property p_disable_keeps;
    (wr_stb && wr_data == 8'h83) |=> ($stable(first_addr) && $stable(second_addr) && $stable(byte_count)) [*2];
  endproperty
  a_disable_keeps: assert property (p_disable_keeps) else $error("disable changed a counter");
  property p_load;
    (wr_stb && wr_data == 8'hCF) |-> ##2 byte_count == 16'h0000;
  endproperty
  a_load: assert property (p_load) else $error("load left byte counter");
  property p_continue;
    (wr_stb && wr_data == 8'hD3) |-> ##2 (byte_count == 16'h0000 && first_addr == $past(first_addr, 2));
  endproperty
  a_continue: assert property (p_continue) else $error("continue misbehaved");
  property p_timing_reset;
    (wr_stb && wr_data == 8'hC7) |-> ##2 first_timing == 2'h3;
  endproperty
  a_timing_reset: assert property (p_timing_reset) else $error("first timing not restored");
  property p_force_ready;
    (wr_stb && wr_data == 8'hB3) |-> ##2 ready_eff;
  endproperty
  a_force_ready: assert property (p_force_ready) else $error("ready not forced");
  property p_quiet;
    !enabled [*2] |-> !bus_request;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus request while disabled");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dma_cmd_regs dma_cmd_asserts u_chk (
  .clock(clock), .rst_n(rst_n), .wr_stb(wr_stb), .wr_data(wr_data), .bus_request(bus_request),
  .first_timing(first_timing), .first_addr(first_addr), .second_addr(second_addr),
  .byte_count(byte_count), .ready_eff(ready_eff), .enabled(enabled));

// ---- sim/host_bus_model.sv ----
/*
  Host processor model that writes command bytes and reads registers.
  Assumes the block takes each strobe on the rising clock edge.
*/
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic       clock,
  input  wire logic [7:0] rd_data,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic      [7:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = 8'hFF;
  end
  // A released data bus shows the inverse of the last byte, never a stale copy.
  task automatic wr(input logic [7:0] b);
    @(negedge clock);
    wr_stb = 1'b1;
    wr_data = b;
    @(negedge clock);
    wr_stb = 1'b0;
    wr_data = ~b;
  endtask
  task automatic rd(output logic [7:0] b);
    @(negedge clock);
    rd_stb = 1'b1;
    @(negedge clock);
    rd_stb = 1'b0;
    @(negedge clock);
    b = rd_data;
  endtask
endmodule

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for the DMA command block.
  Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ns
module tb_top;
  import dma_cmd_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        ready_pin = 1'b0;
  logic        interrupt_return_instruction = 1'b0;
  logic        op_done = 1'b0, end_of_block = 1'b0, int_ack = 1'b0, chain_en = 1'b0;
  logic [7:0]  op_data = 8'h00;
  logic        wr_stb, rd_stb, vector_drive_n, bus_request, int_pulse_n, src_first_port;
  logic        write_port_used, ready_eff, enabled;
  logic [7:0]  wr_data, rd_data, vector_out;
  logic [1:0]  first_timing, second_timing;
  logic [15:0] first_addr, second_addr, byte_count;
  xfer_mode_e  xfer_mode;
  int          miscompares = 0;
  int          checks_done = 0;
  always #25 clock = ~clock;
  dma_cmd_regs u_dut (
    .clock(clock), .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
    .rd_data(rd_data), .op_done(op_done), .op_data(op_data), .end_of_block(end_of_block),
    .ready_pin(ready_pin),
    .interrupt_return_instruction(interrupt_return_instruction), .int_ack(int_ack), .int_enable_in(chain_en),
    .vector_out(vector_out), .vector_drive_n(vector_drive_n), .bus_request(bus_request),
    .int_pulse_n(int_pulse_n), .src_first_port(src_first_port), .write_port_used(write_port_used),
    .xfer_mode(xfer_mode), .first_timing(first_timing), .second_timing(second_timing),
    .first_addr(first_addr), .second_addr(second_addr), .byte_count(byte_count),
    .ready_eff(ready_eff), .enabled(enabled));
  host_bus_model u_host (
    .clock(clock), .rd_data(rd_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      u_host.wr(q[i]);
    end
    cyc(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("enabled", 16'h0, enabled);
    chk("bus_request", 16'h0, bus_request);
    chk("int_pulse_n", 16'h1, int_pulse_n);
    $display("test reset done");
  endtask
  task automatic t_enable();
    send('{8'h87});
    chk("enabled", 16'h1, enabled);
    send('{8'hAB});
    chk("enabled", 16'h0, enabled);
    send('{8'h87, 8'h83});
    chk("enabled", 16'h0, enabled);
    $display("test enable done");
  endtask
  task automatic t_program();
    logic [7:0] b;
    logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h34, 8'h12, 8'h78, 8'h56};
    send('{8'h79, 8'h34, 8'h12, 8'h00, 8'h01, 8'hCD, 8'h78, 8'h56, 8'hCF});
    chk("first_addr", 16'h1234, first_addr);
    chk("second_addr", 16'h5678, second_addr);
    chk("byte_count", 16'h0000, byte_count);
    chk("src_first_port", 16'h0, src_first_port);
    chk("write_port_used", 16'h1, write_port_used);
    chk("xfer_mode", 16'(MODE_BURST), 16'(xfer_mode));
    send('{8'hBB, 8'h7F, 8'hA7});
    u_host.rd(b);
    foreach (exp[i]) begin
      u_host.rd(b);
      chk("readback", 16'(exp[i]), 16'(b));
    end
    send('{8'hD3});
    chk("first_addr", 16'h1234, first_addr);
    send('{8'h02});
    chk("write_port_used", 16'h0, write_port_used);
    $display("test program done");
  endtask
  task automatic t_mask();
    logic [7:0] b;
    send('{8'hBB, 8'h28, 8'hA7});
    u_host.rd(b);
    chk("masked read", 16'h0034, 16'(b));
    send('{8'hBF});
    u_host.rd(b);
    chk("status", 16'h0003, 16'(b));
    u_host.rd(b);
    chk("read after status", 16'h0078, 16'(b));
    $display("test mask done");
  endtask
  task automatic t_timing();
    send('{8'h4C, 8'h0E, 8'h48, 8'h0D});
    chk("first_timing", 16'h2, 16'(first_timing));
    chk("second_timing", 16'h1, 16'(second_timing));
    send('{8'hC7});
    chk("first_timing", 16'h3, 16'(first_timing));
    chk("second_timing", 16'h1, 16'(second_timing));
    send('{8'hCB});
    chk("second_timing", 16'h3, 16'(second_timing));
    $display("test timing done");
  endtask
  task automatic t_ready();
    int n;
    send('{8'hB3});
    cyc(4);
    chk("ready_eff", 16'h1, ready_eff);
    ready_pin = 1'b1;
    cyc(4);
    chk("ready_eff", 16'h1, ready_eff);
    send('{8'hB7, 8'h87});
    cyc(8);
    chk("bus_request", 16'h0, bus_request);
    interrupt_return_instruction = 1'b1;
    cyc(1);
    interrupt_return_instruction = 1'b0;
    for (n = 0; n < 20 && bus_request !== 1'b1; n++) begin
      cyc(1);
    end
    chk("bus_request", 16'h1, bus_request);
    send('{8'h83});
    cyc(1);
    chk("bus_request", 16'h0, bus_request);
    $display("test ready done");
  endtask
  task automatic t_events();
    send('{8'h98, 8'h0F, 8'h50, 8'h91, 8'h31, 8'hA0, 8'hAB, 8'h87});
    op_data = 8'h5A;
    op_done = 1'b1;
    cyc(1);
    op_done = 1'b0;
    end_of_block = 1'b1;
    cyc(1);
    end_of_block = 1'b0;
    int_ack = 1'b1;
    chain_en = 1'b1;
    cyc(2);
    chk("first_addr", 16'h1234, first_addr);
    chk("second_addr", 16'h5677, second_addr);
    chk("vector_out", 16'h00A6, 16'(vector_out));
    chk("vector_drive_n", 16'h0, vector_drive_n);
    int_ack = 1'b0;
    send('{8'h8B});
    chk("vector_out", 16'h00A0, 16'(vector_out));
    $display("test events done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_n = 1'b1;
    t_reset();
    t_enable();
    t_program();
    t_mask();
    t_timing();
    t_ready();
    t_events();
    conclude();
  end
  // The tests need under two hundred cycles; twenty times that means a hang.
  initial begin
    #(50 * 4000);
    miscompares++;
    conclude();
  end
endmodule
